// [i2c_fast_pkg.sv]
// constants and types for the fast timing and status block
package i2c_fast_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_FAST_HIGH = 32'h5000131c;
  localparam logic [31:0] ADDR_FAST_LOW = 32'h50001320;
  localparam logic [31:0] ADDR_EVENT_STATUS = 32'h5000132c;
  localparam logic [31:0] ADDR_EVENT_MASK = 32'h50001330;
  localparam logic [31:0] ADDR_ENABLE = 32'h50001380;
  localparam logic [31:0] ADDR_CLR_GEN_CALL = 32'h50001384;
  localparam logic [31:0] ADDR_CLR_ACTIVITY = 32'h50001388;
  localparam logic [31:0] ADDR_CLR_ALL = 32'h5000138c;
  // reset values and clamps
  localparam logic [15:0] FAST_HIGH_RESET = 16'h8;
  localparam logic [15:0] FAST_LOW_RESET = 16'h17;
  localparam logic [15:0] FAST_HIGH_MIN = 16'h6;
  localparam logic [15:0] FAST_LOW_MIN = 16'h8;
  localparam logic [15:0] MASK_RESET = 16'h800;
  localparam logic [15:0] MASK_WRITABLE = 16'hf80;
  // status bit positions
  localparam int BIT_GEN_CALL = 11;
  localparam int BIT_START = 10;
  localparam int BIT_STOP = 9;
  localparam int BIT_ACTIVITY = 8;
  localparam int BIT_TX_DONE = 7;
  // link events crossing into the register domain
  localparam int EV_START = 0;
  localparam int EV_STOP = 1;
  localparam int EV_GEN_CALL = 2;
  localparam int EV_TX_DONE = 3;
  localparam int EV_RX_BYTE = 4;
  localparam int EV_COUNT = 5;
  // byte framing on the bus
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_CLOCK = 4'h9;
  typedef enum logic [1:0] {SPEED_STD = 2'h1, SPEED_FAST = 2'h2, SPEED_HIGH = 2'h3} speed_t;
  typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_LOW = 2'h1, PH_HIGH = 2'h3} scl_phase_t;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_RX = 3'h3,
    ST_TX = 3'h2,
    ST_SKIP = 3'h6
  } slave_state_t;
endpackage : i2c_fast_pkg

// [scl_timing_if.sv]
// timing bundle between the link logic and the scl period generator
`timescale 1ns/1ns
interface scl_timing_if;
  logic [15:0] high_count;
  logic [15:0] low_count;
  logic run;
  logic scl_level;
  logic scl_oe_n;
  modport gen (input high_count, input low_count, input run, input scl_level, output scl_oe_n);
  modport ctrl (output high_count, output low_count, output run, output scl_level,
    input scl_oe_n);
endinterface : scl_timing_if

// [event_sync.sv]
// toggle crossing of a one-cycle event between two clock domains
`timescale 1ns/1ns
module event_sync
(
  input wire logic i_src_clock, // source clock
  input wire logic i_src_rst, // source reset, high
  input wire logic i_src_pulse, // one-cycle event, source domain
  input wire logic i_dst_clock, // destination clock
  input wire logic i_dst_rst, // destination reset, high
  output logic o_dst_pulse // one-cycle event, destination domain
);
  logic toggle_q, toggle_d;
  logic meta_q, sync_q, last_q, pulse_d;

  // source side flips a level per event so no pulse can be missed
  always_comb
  begin
    toggle_d = toggle_q ^ i_src_pulse;
    pulse_d = sync_q ^ last_q;
  end

  always_ff @(posedge i_src_clock)
  begin
    if (i_src_rst) toggle_q <= 1'b0;
    else toggle_q <= toggle_d;
  end

  // meta_q feeds only sync_q
  always_ff @(posedge i_dst_clock)
  begin
    if (i_dst_rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      o_dst_pulse <= 1'b0;
    end
    else
    begin
      meta_q <= toggle_q;
      sync_q <= meta_q;
      last_q <= sync_q;
      o_dst_pulse <= pulse_d;
    end
  end
endmodule : event_sync

// [fast_scl_gen.sv]
// scl high and low period generator on the link clock
`timescale 1ns/1ns
module fast_scl_gen
  import i2c_fast_pkg::*;
(
  input wire logic i_link_clock, // link clock
  input wire logic i_link_rst, // link reset, high
  scl_timing_if.gen tim // counts in, scl drive out
);
  scl_phase_t phase_q, phase_d;
  logic [15:0] count_q, count_d;
  logic oe_n_q, oe_n_d;

  // high phase counts only while scl reads high: a stretching slave holds it
  always_comb
  begin
    phase_d = phase_q;
    count_d = count_q;
    oe_n_d = oe_n_q;
    if (!tim.run)
    begin
      phase_d = PH_IDLE;
      count_d = 16'h0;
      oe_n_d = 1'b1;
    end
    else
    begin
      case (phase_q)
        PH_IDLE:
        begin
          phase_d = PH_LOW;
          count_d = 16'h0;
          oe_n_d = 1'b0;
        end
        PH_LOW:
        begin
          count_d = count_q + 16'h1;
          if (count_q == tim.low_count - 16'h1)
          begin
            phase_d = PH_HIGH;
            count_d = 16'h0;
            oe_n_d = 1'b1;
          end
        end
        PH_HIGH:
        begin
          if (tim.scl_level)
          begin
            count_d = count_q + 16'h1;
            if (count_q == tim.high_count - 16'h1)
            begin
              phase_d = PH_LOW;
              count_d = 16'h0;
              oe_n_d = 1'b0;
            end
          end
        end
        default: phase_d = PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_link_clock)
  begin
    if (i_link_rst)
    begin
      phase_q <= PH_IDLE;
      count_q <= 16'h0;
      oe_n_q <= 1'b1;
    end
    else
    begin
      phase_q <= phase_d;
      count_q <= count_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign tim.scl_oe_n = oe_n_q;
endmodule : fast_scl_gen

// [i2c_fast_timing_status.sv]
// fast scl timing registers, bus event detection and masked event status
//
// Overview of operation
// - 16-bit fast high count, resets to eight, sets scl high cycles.
// - 16-bit fast low count, resets to 0x17, sets scl low cycles.
// - hs master code, start byte, general call use fast counts; the code selects them only for fast speed and the hs code.
// - count writes land only while enable is zero.
// - high count written below six stores six.
// - low count written below eight stores eight.
// - acked general call sets its flag; following data goes to receive.
// - general call flag holds until disable, its clear read or all-clear read.
// - status bit 10 reports start or repeated start, master or slave.
// - status bit 9 reports stop, master or slave.
// - activity flag sets on any activity while enable is one, stays set when idle.
// - activity clears only by disable, its clear read, all-clear read, reset.
// - slave transmitter: unacknowledged byte sets status bit 7.
// - mask bits gate status bits; general call mask resets to one.
`timescale 1ns/1ns
module i2c_fast_timing_status
  import i2c_fast_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = 7'h55 // slave address, plain default
)
(
  input wire logic i_clock, // register clock
  input wire logic i_sys_rst, // synchronous reset, high
  input wire logic i_psel, // register port select
  input wire logic i_penable, // access phase
  input wire logic i_pwrite, // register port write
  input wire logic [31:0] i_paddr, // register byte address
  input wire logic [31:0] i_pwdata, // register write data
  output logic [31:0] o_prdata, // register read data
  output logic o_pready, // register port ready
  output logic o_pslverr, // unmapped address
  input wire logic i_link_clock, // link clock
  input wire logic i_scl, // scl pin level
  input wire logic i_sda, // sda pin level
  output logic o_scl_out, // scl drive value, always low
  output logic o_scl_oe_n, // scl driven low when 0
  output logic o_sda_out, // sda drive value, always low
  output logic o_sda_oe_n, // sda driven low when 0
  input wire logic i_link_scl_req, // master wants scl, link domain
  input wire i2c_fast_pkg::speed_t i_link_speed, // bus speed, link domain
  input wire logic i_link_hs_code, // sending hs preamble, link domain
  input wire logic [7:0] i_tx_data, // byte for slave transmit
  input wire logic i_tx_load, // load i_tx_data, one cycle
  output logic [7:0] o_rx_data, // received data byte
  output logic o_rx_strobe // o_rx_data valid, one cycle
);
  // register domain state
  logic enable_q, enable_d;
  logic [15:0] fast_high_q, fast_high_d;
  logic [15:0] fast_low_q, fast_low_d;
  logic [15:0] mask_q, mask_d;
  logic gen_call_q, gen_call_d, start_q, start_d, stop_q, stop_d;
  logic activity_q, activity_d, tx_done_q, tx_done_d;
  logic [31:0] rdata_q, rdata_d;
  logic slverr_q, slverr_d, pready_q, pready_d;
  logic [7:0] rx_data_q, rx_data_d, tx_hold_q, tx_hold_d;
  logic rx_strobe_q, rx_strobe_d;
  logic act_meta_q, act_sync_q;
  logic [EV_COUNT-1:0] ev_sys;
  logic setup, wr, rd, mapped;
  logic hit_high, hit_low, hit_stat, hit_mask, hit_en, hit_clr_gc, hit_clr_act, hit_clr_all;
  logic [15:0] raw_status;

  // link domain state
  logic lrst_meta_q, lrst_q, en_meta_q, en_link_q;
  logic [15:0] hi_copy_q, hi_copy_d, lo_copy_q, lo_copy_d;
  logic scl_meta_q, scl_s_q, scl_prev_q, sda_meta_q, sda_s_q, sda_prev_q;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  slave_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d, txsh_q, txsh_d, tx_byte_q, tx_byte_d, rx_byte_q, rx_byte_d;
  logic ack_q, ack_d, busy_q, busy_d, drive, sda_oe_n_q, sda_oe_n_d;
  logic active_q, active_d, fast_sel, tx_load_link;
  logic [EV_COUNT-1:0] ev_q, ev_d;
  scl_timing_if tim ();

  // register port decode
  always_comb
  begin
    setup = i_psel & !i_penable;
    wr = i_psel & i_penable & i_pwrite;
    rd = i_psel & i_penable & !i_pwrite;
    hit_high = i_paddr == ADDR_FAST_HIGH;
    hit_low = i_paddr == ADDR_FAST_LOW;
    hit_stat = i_paddr == ADDR_EVENT_STATUS;
    hit_mask = i_paddr == ADDR_EVENT_MASK;
    hit_en = i_paddr == ADDR_ENABLE;
    hit_clr_gc = i_paddr == ADDR_CLR_GEN_CALL;
    hit_clr_act = i_paddr == ADDR_CLR_ACTIVITY;
    hit_clr_all = i_paddr == ADDR_CLR_ALL;
    mapped = hit_high | hit_low | hit_stat | hit_mask | hit_en | hit_clr_gc | hit_clr_act
      | hit_clr_all;
  end

  // raw event bits; reserved bits stay zero
  always_comb
  begin
    raw_status = 16'h0;
    raw_status[BIT_GEN_CALL] = gen_call_q;
    raw_status[BIT_START] = start_q;
    raw_status[BIT_STOP] = stop_q;
    raw_status[BIT_ACTIVITY] = activity_q;
    raw_status[BIT_TX_DONE] = tx_done_q;
  end

  // register writes; read data taken at setup, stable through access
  always_comb
  begin
    enable_d = enable_q;
    fast_high_d = fast_high_q;
    fast_low_d = fast_low_q;
    mask_d = mask_q;
    rdata_d = rdata_q;
    slverr_d = slverr_q;
    pready_d = 1'b1;
    tx_hold_d = i_tx_load ? i_tx_data : tx_hold_q;
    if (setup)
    begin
      slverr_d = !mapped;
      rdata_d = 32'h0;
      if (hit_high) rdata_d = {16'h0, fast_high_q};
      if (hit_low) rdata_d = {16'h0, fast_low_q};
      if (hit_stat) rdata_d = {16'h0, raw_status & mask_q};
      if (hit_mask) rdata_d = {16'h0, mask_q};
      if (hit_en) rdata_d = {31'h0, enable_q};
      if (hit_clr_gc) rdata_d = {31'h0, gen_call_q};
      if (hit_clr_act) rdata_d = {31'h0, activity_q};
      if (hit_clr_all) rdata_d = {31'h0, |raw_status};
    end
    if (wr && hit_high && !enable_q)
      fast_high_d = (i_pwdata[15:0] < FAST_HIGH_MIN) ? FAST_HIGH_MIN : i_pwdata[15:0];
    if (wr && hit_low && !enable_q)
      fast_low_d = (i_pwdata[15:0] < FAST_LOW_MIN) ? FAST_LOW_MIN : i_pwdata[15:0];
    if (wr && hit_mask) mask_d = i_pwdata[15:0] & MASK_WRITABLE;
    if (wr && hit_en) enable_d = i_pwdata[0];
  end

  // sticky flags; a set wins over a same-cycle clear
  always_comb
  begin
    gen_call_d = ev_sys[EV_GEN_CALL]
      | (gen_call_q & enable_q & !(rd && (hit_clr_gc || hit_clr_all)));
    start_d = ev_sys[EV_START] | (start_q & !(rd && hit_clr_all));
    stop_d = ev_sys[EV_STOP] | (stop_q & !(rd && hit_clr_all));
    activity_d = (act_sync_q & enable_q)
      | (activity_q & enable_q & !(rd && (hit_clr_act || hit_clr_all)));
    tx_done_d = ev_sys[EV_TX_DONE] | (tx_done_q & !(rd && hit_clr_all));
    rx_strobe_d = ev_sys[EV_RX_BYTE];
    rx_data_d = ev_sys[EV_RX_BYTE] ? rx_byte_q : rx_data_q;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      enable_q <= 1'b0;
      fast_high_q <= FAST_HIGH_RESET;
      fast_low_q <= FAST_LOW_RESET;
      mask_q <= MASK_RESET;
      gen_call_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      activity_q <= 1'b0;
      tx_done_q <= 1'b0;
      rdata_q <= 32'h0;
      slverr_q <= 1'b0;
      pready_q <= 1'b0;
      tx_hold_q <= 8'h0;
      rx_data_q <= 8'h0;
      rx_strobe_q <= 1'b0;
      act_meta_q <= 1'b0;
      act_sync_q <= 1'b0;
    end
    else
    begin
      enable_q <= enable_d;
      fast_high_q <= fast_high_d;
      fast_low_q <= fast_low_d;
      mask_q <= mask_d;
      gen_call_q <= gen_call_d;
      start_q <= start_d;
      stop_q <= stop_d;
      activity_q <= activity_d;
      tx_done_q <= tx_done_d;
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
      pready_q <= pready_d;
      tx_hold_q <= tx_hold_d;
      rx_data_q <= rx_data_d;
      rx_strobe_q <= rx_strobe_d;
      act_meta_q <= active_q;
      act_sync_q <= act_meta_q;
    end
  end

  // link reset, enable and pin synchronisers
  always_ff @(posedge i_link_clock)
  begin
    lrst_meta_q <= i_sys_rst;
    lrst_q <= lrst_meta_q;
    en_meta_q <= enable_q;
    en_link_q <= en_meta_q;
    scl_meta_q <= i_scl;
    scl_s_q <= scl_meta_q;
    scl_prev_q <= scl_s_q;
    sda_meta_q <= i_sda;
    sda_s_q <= sda_meta_q;
    sda_prev_q <= sda_s_q;
  end

  // counts copied only while disabled, long before the generator may run
  always_comb
  begin
    hi_copy_d = en_link_q ? hi_copy_q : fast_high_q;
    lo_copy_d = en_link_q ? lo_copy_q : fast_low_q;
  end

  // bus conditions from the synchronised pins
  always_comb
  begin
    scl_rise = scl_s_q & !scl_prev_q;
    scl_fall = !scl_s_q & scl_prev_q;
    start_cond = scl_s_q & scl_prev_q & sda_prev_q & !sda_s_q;
    stop_cond = scl_s_q & scl_prev_q & !sda_prev_q & sda_s_q;
    fast_sel = (i_link_speed == SPEED_FAST) || ((i_link_speed == SPEED_HIGH) && i_link_hs_code);
  end

  // fast counts also serve the hs preamble
  assign tim.high_count = hi_copy_q;
  assign tim.low_count = lo_copy_q;
  assign tim.run = en_link_q & i_link_scl_req & fast_sel;
  assign tim.scl_level = scl_s_q;

  // slave byte engine
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    txsh_d = txsh_q;
    ack_d = ack_q;
    busy_d = busy_q;
    rx_byte_d = rx_byte_q;
    tx_byte_d = tx_load_link ? tx_hold_q : tx_byte_q;
    ev_d = '0;
    drive = !sda_oe_n_q;
    if (start_cond)
    begin
      busy_d = 1'b1;
      ev_d[EV_START] = 1'b1;
      state_d = en_link_q ? ST_ADDR : ST_SKIP;
      cnt_d = 4'h0;
      drive = 1'b0;
    end
    else if (stop_cond)
    begin
      busy_d = 1'b0;
      ev_d[EV_STOP] = 1'b1;
      state_d = ST_IDLE;
      drive = 1'b0;
    end
    else if (!en_link_q)
    begin
      state_d = ST_IDLE;
      drive = 1'b0;
    end
    else if (scl_rise)
    begin
      if (cnt_q < BYTE_BITS) shift_d = {shift_q[6:0], sda_s_q};
      // master nack on our byte ends the transmission
      if (state_q == ST_TX && cnt_q == BYTE_BITS && sda_s_q)
      begin
        ev_d[EV_TX_DONE] = 1'b1;
        state_d = ST_SKIP;
      end
      cnt_d = cnt_q + 4'h1;
    end
    else if (scl_fall)
    begin
      if (cnt_q == BYTE_BITS)
      begin
        case (state_q)
          ST_ADDR:
          begin
            ack_d = (shift_q == GEN_CALL_ADDR) || (shift_q[7:1] == OWN_ADDR);
            ev_d[EV_GEN_CALL] = (shift_q == GEN_CALL_ADDR);
          end
          ST_RX:
          begin
            ack_d = 1'b1;
            rx_byte_d = shift_q;
            ev_d[EV_RX_BYTE] = 1'b1;
          end
          default: ack_d = ack_q;
        endcase
      end
      if (cnt_q == LAST_CLOCK)
      begin
        cnt_d = 4'h0;
        if (state_q == ST_ADDR)
          state_d = !ack_q ? ST_SKIP : (shift_q[0] ? ST_TX : ST_RX);
        if (state_d == ST_TX) txsh_d = tx_byte_q;
      end
      else if (state_q == ST_TX && cnt_q != BYTE_BITS)
        txsh_d = {txsh_q[6:0], 1'b0};
      case (state_d)
        ST_ADDR, ST_RX: drive = (cnt_q == BYTE_BITS) && ack_d;
        ST_TX: drive = (cnt_d < BYTE_BITS) && !txsh_d[7];
        default: drive = 1'b0;
      endcase
    end
    sda_oe_n_d = !drive;
    active_d = busy_d | tim.run;
  end

  always_ff @(posedge i_link_clock)
  begin
    if (lrst_q)
    begin
      hi_copy_q <= FAST_HIGH_RESET;
      lo_copy_q <= FAST_LOW_RESET;
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h0;
      txsh_q <= 8'h0;
      tx_byte_q <= 8'h0;
      rx_byte_q <= 8'h0;
      ack_q <= 1'b0;
      busy_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      active_q <= 1'b0;
      ev_q <= '0;
    end
    else
    begin
      hi_copy_q <= hi_copy_d;
      lo_copy_q <= lo_copy_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      txsh_q <= txsh_d;
      tx_byte_q <= tx_byte_d;
      rx_byte_q <= rx_byte_d;
      ack_q <= ack_d;
      busy_q <= busy_d;
      sda_oe_n_q <= sda_oe_n_d;
      active_q <= active_d;
      ev_q <= ev_d;
    end
  end

  // link events into the register domain
  for (genvar e = 0; e < EV_COUNT; e++)
  begin : g_ev
    event_sync u_ev
    (
      .i_src_clock(i_link_clock),
      .i_src_rst(lrst_q),
      .i_src_pulse(ev_q[e]),
      .i_dst_clock(i_clock),
      .i_dst_rst(i_sys_rst),
      .o_dst_pulse(ev_sys[e])
    );
  end

  // transmit load into the link domain; tx_hold_q is stable by then
  event_sync u_tx_load
  (
    .i_src_clock(i_clock),
    .i_src_rst(i_sys_rst),
    .i_src_pulse(i_tx_load),
    .i_dst_clock(i_link_clock),
    .i_dst_rst(lrst_q),
    .o_dst_pulse(tx_load_link)
  );

  fast_scl_gen u_scl_gen
  (
    .i_link_clock(i_link_clock),
    .i_link_rst(lrst_q),
    .tim(tim.gen)
  );

  // outputs; open-drain lines only ever pull low
  assign o_prdata = rdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = slverr_q;
  assign o_rx_data = rx_data_q;
  assign o_rx_strobe = rx_strobe_q;
  assign o_scl_oe_n = tim.scl_oe_n;
  assign o_scl_out = 1'b0;
  assign o_sda_oe_n = sda_oe_n_q;
  assign o_sda_out = 1'b0;
endmodule : i2c_fast_timing_status

// [i2c_fast_timing_status_assertions.sv]
// port checks for the fast timing and status block
`timescale 1ns/1ns
module i2c_fast_timing_status_assertions
  import i2c_fast_pkg::*;
(
  input wire logic i_clock, // register clock
  input wire logic i_sys_rst, // synchronous reset, high
  input wire logic i_psel, // port select
  input wire logic i_penable, // access phase
  input wire logic i_pwrite, // write
  input wire logic [31:0] i_paddr, // byte address
  input wire logic [31:0] i_pwdata, // write data
  input wire logic [31:0] o_prdata, // read data
  input wire logic o_pready, // ready
  input wire logic o_rx_strobe, // received byte strobe
  input wire logic o_scl_oe_n // scl pulled low when 0
);
  logic [15:0] hi_q, hi_d, lo_q, lo_d, mask_q, mask_d;
  logic en_q, en_d;
  logic [7:0] dis_q, dis_d;
  logic wr, rd;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // completed accesses
  assign wr = i_psel & i_penable & i_pwrite & o_pready;
  assign rd = i_psel & i_penable & !i_pwrite;
  // software-visible shadow; disabled-time counter
  always_comb
  begin
    hi_d = hi_q;
    lo_d = lo_q;
    mask_d = mask_q;
    en_d = en_q;
    if (wr && !en_q && i_paddr == ADDR_FAST_HIGH)
      hi_d = (i_pwdata[15:0] < FAST_HIGH_MIN) ? FAST_HIGH_MIN : i_pwdata[15:0];
    if (wr && !en_q && i_paddr == ADDR_FAST_LOW)
      lo_d = (i_pwdata[15:0] < FAST_LOW_MIN) ? FAST_LOW_MIN : i_pwdata[15:0];
    if (wr && i_paddr == ADDR_EVENT_MASK)
      mask_d = i_pwdata[15:0] & MASK_WRITABLE;
    if (wr && i_paddr == ADDR_ENABLE)
      en_d = i_pwdata[0];
    dis_d = en_q ? 8'h0 : ((dis_q == 8'hff) ? dis_q : dis_q + 8'h1);
  end
  always_ff @(posedge i_clock)
  begin
    hi_q <= i_sys_rst ? FAST_HIGH_RESET : hi_d;
    lo_q <= i_sys_rst ? FAST_LOW_RESET : lo_d;
    mask_q <= i_sys_rst ? MASK_RESET : mask_d;
    en_q <= i_sys_rst ? 1'b0 : en_d;
    dis_q <= i_sys_rst ? 8'h0 : dis_d;
  end
  a_ready_after_reset: assert property (!$past(i_sys_rst) |-> o_pready)
    else $error("ready low after reset");
  a_reserved_zero: assert property (
    rd && i_paddr == ADDR_EVENT_STATUS |-> o_prdata[31:12] == 20'h0)
    else $error("reserved status bits set");
  a_high_shadow: assert property (
    rd && i_paddr == ADDR_FAST_HIGH |-> o_prdata == {16'h0, hi_q})
    else $error("fast high count wrong");
  a_low_shadow: assert property (
    rd && i_paddr == ADDR_FAST_LOW |-> o_prdata == {16'h0, lo_q})
    else $error("fast low count wrong");
  a_mask_gates: assert property (
    rd && i_paddr == ADDR_EVENT_STATUS |-> (o_prdata[15:0] & ~mask_q) == 16'h0)
    else $error("masked bit visible");
  a_off_flags_clear: assert property (
    rd && i_paddr == ADDR_EVENT_STATUS && dis_q > 8'h06 |-> !o_prdata[11] && !o_prdata[8])
    else $error("flag kept while disabled");
  a_strobe_single: assert property (o_rx_strobe |=> !o_rx_strobe)
    else $error("receive strobe too long");
  a_scl_quiet_off: assert property (dis_q == 8'hff |-> o_scl_oe_n)
    else $error("scl driven while disabled");
  c_rx_byte: cover property (o_rx_strobe);
  c_gen_call_seen: cover property (rd && i_paddr == ADDR_EVENT_STATUS && o_prdata[11]);
  c_scl_low: cover property (!o_scl_oe_n);
endmodule : i2c_fast_timing_status_assertions

bind i2c_fast_timing_status i2c_fast_timing_status_assertions u_chk (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_rx_strobe(o_rx_strobe), .o_scl_oe_n(o_scl_oe_n));

// [i2c_master_model.sv]
// remote bus master model, open drain on scl and sda
`timescale 1ns/1ns
module i2c_master_model
(
  input wire logic i_sda, // sda wire level
  output logic o_scl_oe_n, // scl pulled low when 0
  output logic o_sda_oe_n // sda pulled low when 0
);
  localparam int T = 1000; // third of a bit, far above the link sync lag
  initial
  begin
    o_scl_oe_n = 1;
    o_sda_oe_n = 1;
  end
  // sda falls while scl is high
  task automatic start_cond();
    o_sda_oe_n = 1;
    #T o_scl_oe_n = 1;
    #T o_sda_oe_n = 0;
    #T o_scl_oe_n = 0;
  endtask : start_cond
  // data changes only while scl is low
  task automatic put_bit(input logic b);
    #T o_sda_oe_n = b;
    #T o_scl_oe_n = 1;
    #T o_scl_oe_n = 0;
  endtask : put_bit
  task automatic get_bit(output logic b);
    #T o_sda_oe_n = 1;
    #T o_scl_oe_n = 1;
    #(T / 2) b = i_sda;
    #(T / 2) o_scl_oe_n = 0;
  endtask : get_bit
  // msb first, then the acknowledge slot
  task automatic write_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    get_bit(ack);
  endtask : write_byte
  task automatic read_byte(output logic [7:0] d, input logic nack);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(nack);
  endtask : read_byte
  // sda rises while scl is high
  task automatic stop_cond();
    #T o_sda_oe_n = 0;
    #T o_scl_oe_n = 1;
    #T o_sda_oe_n = 1;
    #T;
  endtask : stop_cond
endmodule : i2c_master_model

// [i2c_fast_timing_status_tb_top.sv]
// self-checking bench for the fast timing and status block
`timescale 1ns/1ns
module i2c_fast_timing_status_tb_top;
  import i2c_fast_pkg::*;
  logic i_clock = 0;
  logic lclk = 0;
  logic rst = 1;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic [31:0] paddr = 0;
  logic [31:0] pwd = 0;
  logic [31:0] prd, v;
  logic rdy, err, b, scl_oe_n, sda_oe_n, m_scl, m_sda, rxs;
  wire scl = scl_oe_n & m_scl;
  wire sda = sda_oe_n & m_sda;
  logic req = 0;
  logic hs = 0;
  speed_t spd = SPEED_STD;
  logic [7:0] txd = 0;
  logic txl = 0;
  logic [7:0] rxd, by;
  logic [7:0] rx_got = 0;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  logic [31:0] ta;
  logic [15:0] tw [6] = '{16'h3, 16'h5, 16'h9, 16'h7, 16'h8, 16'hc};
  logic [15:0] te [6] = '{16'h6, 16'h6, 16'h9, 16'h8, 16'h8, 16'hc};
  always #4 i_clock = ~i_clock;
  // link clock, unrelated phase
  initial
  begin
    #3;
    forever #40 lclk = ~lclk;
  end
  i2c_fast_timing_status u_dut (.i_clock(i_clock), .i_sys_rst(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(rdy), .o_pslverr(err), .i_link_clock(lclk), .i_scl(scl), .i_sda(sda),
    .o_scl_out(), .o_scl_oe_n(scl_oe_n), .o_sda_out(), .o_sda_oe_n(sda_oe_n),
    .i_link_scl_req(req), .i_link_speed(spd), .i_link_hs_code(hs), .i_tx_data(txd),
    .i_tx_load(txl), .o_rx_data(rxd), .o_rx_strobe(rxs));
  i2c_master_model u_master (.i_sda(sda), .o_scl_oe_n(m_scl), .o_sda_oe_n(m_sda));
  // strobe spans one falling edge
  always @(negedge i_clock)
    if (rxs === 1'b1) rx_got <= rxd;
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // setup then access; answer taken at the ready edge
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(negedge i_clock);
    psel = 1;
    pwr = w;
    paddr = a;
    pwd = d;
    @(negedge i_clock);
    pen = 1;
    do @(posedge i_clock); while (rdy !== 1'b1);
    v = prd;
    b = err;
    @(negedge i_clock);
    psel = 0;
    pen = 0;
  endtask : acc
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    acc(0, a, 0);
    chk($sformatf("reg %h", a), e, v);
  endtask : rd
  // next scl low phase in link clocks, 0 if none
  task automatic scl_low(output int k);
    k = 0;
    for (int i = 0; i < 60 && scl_oe_n !== 1'b0; i++) @(negedge lclk);
    while (scl_oe_n === 1'b0)
    begin
      k++;
      @(negedge lclk);
    end
  endtask : scl_low
  task automatic set_link(input speed_t s, input logic r, input logic h);
    @(negedge i_clock);
    spd = s;
    req = r;
    hs = h;
  endtask : set_link
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial
  begin
    // reset spans several link clocks
    repeat (44) @(negedge i_clock);
    rst = 0;
    repeat (40) @(negedge i_clock);
    rd(ADDR_FAST_HIGH, 32'h8);
    rd(ADDR_FAST_LOW, 32'h17);
    rd(ADDR_EVENT_MASK, 32'h800);
    rd(ADDR_EVENT_STATUS, 32'h0);
    $display("test resets done");
    for (int i = 0; i < 6; i++)
    begin
      ta = (i < 3) ? ADDR_FAST_HIGH : ADDR_FAST_LOW;
      acc(1, ta, {16'h0, tw[i]});
      rd(ta, {16'h0, te[i]});
    end
    $display("test clamps done");
    acc(1, ADDR_ENABLE, 32'h1);
    acc(1, ADDR_FAST_HIGH, 32'h20);
    rd(ADDR_FAST_HIGH, 32'h9);
    acc(1, ADDR_EVENT_STATUS, 32'hffff);
    rd(ADDR_EVENT_STATUS, 32'h0);
    rd(32'h50001324, 32'h0);
    chk("slave error", 32'h1, {31'h0, b});
    $display("test locks done");
    set_link(SPEED_FAST, 1, 0);
    scl_low(n);
    chk("fast low", 32'hc, n);
    set_link(SPEED_FAST, 0, 0);
    repeat (30) @(negedge lclk);
    set_link(SPEED_HIGH, 1, 0);
    scl_low(n);
    chk("high no code", 32'h0, n);
    set_link(SPEED_HIGH, 1, 1);
    scl_low(n);
    chk("high code low", 32'hc, n);
    set_link(SPEED_FAST, 0, 0);
    repeat (30) @(negedge lclk);
    $display("test scl timing done");
    acc(1, ADDR_ENABLE, 32'h0);
    acc(1, ADDR_EVENT_MASK, 32'hffff);
    rd(ADDR_EVENT_MASK, 32'hf80);
    u_master.start_cond();
    u_master.write_byte(8'h00, b);
    u_master.stop_cond();
    chk("ack when off", 32'h1, {31'h0, b});
    rd(ADDR_EVENT_STATUS, 32'h600);
    rd(ADDR_CLR_ALL, 32'h1);
    rd(ADDR_EVENT_STATUS, 32'h0);
    acc(1, ADDR_ENABLE, 32'h1);
    u_master.start_cond();
    u_master.write_byte(8'h00, b);
    chk("ack gen call", 32'h0, {31'h0, b});
    u_master.write_byte(8'ha5, b);
    u_master.stop_cond();
    chk("rx byte", 32'ha5, {24'h0, rx_got});
    rd(ADDR_EVENT_STATUS, 32'hf00);
    rd(ADDR_CLR_GEN_CALL, 32'h1);
    rd(ADDR_EVENT_STATUS, 32'h700);
    rd(ADDR_CLR_ACTIVITY, 32'h1);
    rd(ADDR_EVENT_STATUS, 32'h600);
    rd(ADDR_CLR_ALL, 32'h1);
    $display("test general call done");
    @(negedge i_clock);
    txd = 8'h3c;
    txl = 1;
    @(negedge i_clock);
    txl = 0;
    u_master.start_cond();
    u_master.write_byte({7'h55, 1'b1}, b);
    u_master.read_byte(by, 1'b1);
    u_master.stop_cond();
    chk("tx byte", 32'h3c, {24'h0, by});
    rd(ADDR_EVENT_STATUS, 32'h780);
    acc(1, ADDR_ENABLE, 32'h0);
    rd(ADDR_EVENT_STATUS, 32'h680);
    $display("test slave tx done");
    report_and_stop();
  end
endmodule : i2c_fast_timing_status_tb_top
